//--- rtl/pme_enc4b5b.sv
`timescale 1ns/100ps
`include "pme_regs.svh"
module pme_enc4b5b
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_resetn,
	// nibble stream in, code words out
	pme_nib_if.enc    bus
);
	import pme_pkg::*;

	pme_enc_state_t state_r;
	pme_code_t      code_r;
	pme_code_t      prev_r;
	logic           stb_r;

	function automatic pme_code_t enc_f(input pme_nibble_t n);
		pme_code_t c;
		c = `PME_CODE_D0;
		unique case (n)
			4'h0: c = `PME_CODE_D0;
			4'h1: c = `PME_CODE_D1;
			4'h2: c = `PME_CODE_D2;
			4'h3: c = `PME_CODE_D3;
			4'h4: c = `PME_CODE_D4;
			4'h5: c = `PME_CODE_D5;
			4'h6: c = `PME_CODE_D6;
			4'h7: c = `PME_CODE_D7;
			4'h8: c = `PME_CODE_D8;
			4'h9: c = `PME_CODE_D9;
			4'ha: c = `PME_CODE_DA;
			4'hb: c = `PME_CODE_DB;
			4'hc: c = `PME_CODE_DC;
			4'hd: c = `PME_CODE_DD;
			4'he: c = `PME_CODE_DE;
			4'hf: c = `PME_CODE_DF;
		endcase
		return c;
	endfunction

	assign bus.code     = code_r;
	assign bus.code_stb = stb_r;

	////////////////////////////////////////////////////////////////////////////
	// one code word per transmit clock rise; nothing leaves in slow mode
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			state_r <= pme_enc_idle;
			code_r  <= `PME_CODE_I;
			prev_r  <= `PME_CODE_I;
			stb_r   <= 1'b0;
		end
		else
		begin
			stb_r <= bus.strobe & ~bus.speed_10;
			if (bus.speed_10)
				state_r <= pme_enc_idle;
			else if (bus.strobe)
			begin
				prev_r <= code_r;
				unique case (state_r)
					pme_enc_idle:
						if (bus.en)
						begin
							code_r  <= `PME_CODE_J;
							state_r <= pme_enc_k;
						end
						else
							code_r <= `PME_CODE_I;
					pme_enc_k:
					begin
						code_r  <= `PME_CODE_K;
						state_r <= pme_enc_data;
					end
					pme_enc_data:
						if (bus.en)
							code_r <= enc_f(bus.nibble);
						else
						begin
							code_r  <= `PME_CODE_T;
							state_r <= pme_enc_r;
						end
					pme_enc_r:
					begin
						code_r  <= `PME_CODE_R;
						state_r <= pme_enc_idle;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	ssd_order_a: assert property (stb_r && code_r == `PME_CODE_K |-> prev_r == `PME_CODE_J)
		else $error("k not preceded by j");
	esd_order_a: assert property (stb_r && code_r == `PME_CODE_R |-> prev_r == `PME_CODE_T)
		else $error("r not preceded by t");
	idle_after_a: assert property (stb_r && prev_r == `PME_CODE_R |-> code_r == `PME_CODE_I)
		else $error("no idle after end delimiter");
	data_map_a: assert property (bus.strobe && !bus.speed_10 && bus.en && state_r == pme_enc_data
		|=> code_r == enc_f($past(bus.nibble)) && code_r != 5'h00)
		else $error("data nibble mapped wrong");
	slow_quiet_a: assert property (bus.speed_10 |=> !stb_r)
		else $error("code word emitted in slow mode");
	enc_frame_c: cover property (stb_r && code_r == `PME_CODE_R);
endmodule

//--- rtl/pme_nib_if.sv
`timescale 1ns/100ps
interface pme_nib_if;
	import pme_pkg::*;

	logic        strobe;
	logic        en;
	logic        speed_10;
	pme_nibble_t nibble;
	pme_code_t   code;
	logic        code_stb;

	modport src
	(
		output strobe,
		output en,
		output speed_10,
		output nibble,
		input  code,
		input  code_stb
	);

	modport enc
	(
		input  strobe,
		input  en,
		input  speed_10,
		input  nibble,
		output code,
		output code_stb
	);
endinterface

//--- rtl/pme_phy_mii.sv
`timescale 1ns/100ps
`include "pme_regs.svh"
module pme_phy_mii
#(
	parameter int unsigned SLOW_DIV = `PME_SLOW_DIV
)
(
	// clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	// oscillator pin and speed select
	input  wire logic                 i_oscillator_input,
	input  wire logic                 i_speed_10,
	// transmit side from the controller
	input  wire logic                 i_tx_en,
	input  wire pme_pkg::pme_nibble_t i_txd,
	output logic                      o_tx_clk,
	// receive side to the controller
	output logic                      o_rx_clk,
	output logic                      o_crs,
	output logic                      o_rx_dv,
	output pme_pkg::pme_nibble_t      o_rxd,
	output logic                      o_rx_er,
	output logic                      o_col,
	// line side status from decoder and recovery
	input  wire logic                 i_rx_active,
	input  wire pme_pkg::pme_nibble_t i_rx_nibble,
	input  wire logic                 i_rx_err,
	input  wire logic                 i_squelch_ok,
	input  wire logic                 i_rec_lock,
	input  wire logic                 i_rec_clk,
	input  wire logic                 i_link_fail,
	input  wire logic                 i_collision,
	// line coder outputs
	output pme_pkg::pme_code_t        o_code,
	output logic                      o_code_stb,
	output logic                      o_scr_bypass,
	output pme_pkg::pme_nibble_t      o_man_nibble,
	output logic                      o_man_valid
);
	import pme_pkg::*;

	localparam int unsigned CW = $clog2(SLOW_DIV + 1);

	logic          osc_s1_r;
	logic          osc_s2_r;
	logic          osc_s3_r;
	logic          osc_rise;
	logic          speed_r;
	logic [CW-1:0] div_r;
	logic          tx_clk_r;
	logic          tx_clk_nxt;
	logic          tx_rise;
	logic          strobe_r;
	logic          tx_en_r;
	pme_nibble_t   txd_r;
	pme_nibble_t   man_nibble_r;
	logic          man_valid_r;
	logic          rec_s1_r;
	logic          rec_s2_r;
	logic          rec_sel_r;
	logic          rx_clk_r;
	logic          rx_src;
	logic          rx_fall;
	logic          crs_r;
	logic          crs_nxt;
	logic          dv_r;
	logic          dv_nxt;
	pme_nibble_t   rxd_r;
	logic          er_r;
	logic          col_r;

	pme_nib_if nib ();

	////////////////////////////////////////////////////////////////////////////
	// oscillator pin sampled twice, then its rises found
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end
		else
		begin
			osc_s1_r <= i_oscillator_input;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	assign osc_rise = osc_s2_r & ~osc_s3_r;

	////////////////////////////////////////////////////////////////////////////
	// transmit clock: follows the oscillator in fast mode, divided in slow
	// speed only changes while the clock is low, so no runt pulse leaves
	always_comb
	begin
		tx_clk_nxt = tx_clk_r;
		if (!speed_r)
			tx_clk_nxt = osc_s2_r;
		else if (osc_rise && div_r == CW'(SLOW_DIV - 1))
			tx_clk_nxt = ~tx_clk_r;
	end

	assign tx_rise = tx_clk_nxt & ~tx_clk_r;

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			tx_clk_r <= 1'b0;
			speed_r  <= 1'b0;
			div_r    <= '0;
		end
		else
		begin
			tx_clk_r <= tx_clk_nxt;
			if (osc_rise && !tx_clk_r && div_r == '0)
				speed_r <= i_speed_10;
			if (!speed_r)
				div_r <= '0;
			else if (osc_rise)
				div_r <= (div_r == CW'(SLOW_DIV - 1)) ? '0 : div_r + CW'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// nibble capture on each transmit clock rise
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			strobe_r <= 1'b0;
			tx_en_r  <= 1'b0;
			txd_r    <= '0;
		end
		else
		begin
			strobe_r <= tx_rise;
			if (tx_rise)
			begin
				tx_en_r <= i_tx_en;
				txd_r   <= i_tx_en ? i_txd : 4'h0;
			end
		end
	end

	assign nib.strobe   = strobe_r;
	assign nib.en       = tx_en_r;
	assign nib.nibble   = txd_r;
	assign nib.speed_10 = speed_r;

	pme_enc4b5b u_enc
	(
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.bus      (nib.enc)
	);

	// slow path: nibble handed whole to the manchester coder, bit 0 sent first
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			man_nibble_r <= '0;
			man_valid_r  <= 1'b0;
		end
		else if (strobe_r)
		begin
			man_valid_r  <= tx_en_r & speed_r;
			man_nibble_r <= speed_r ? txd_r : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive clock source; swap only while both candidates are low
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			rec_s1_r  <= 1'b0;
			rec_s2_r  <= 1'b0;
			rec_sel_r <= 1'b0;
			rx_clk_r  <= 1'b0;
		end
		else
		begin
			rec_s1_r <= i_rec_clk;
			rec_s2_r <= rec_s1_r;
			rx_clk_r <= rx_src;
			if (!tx_clk_r && !rec_s2_r)
				rec_sel_r <= i_rec_lock & (speed_r ? crs_r : 1'b1);
		end
	end

	assign rx_src  = rec_sel_r ? rec_s2_r : tx_clk_r;
	assign rx_fall = rx_clk_r & ~rx_src;

	////////////////////////////////////////////////////////////////////////////
	// receive outputs move on receive clock falls; link fail clears them and collision follows on any clock
	assign crs_nxt = i_rx_active & ~i_link_fail & (~speed_r | i_squelch_ok);
	assign dv_nxt  = crs_nxt & (~speed_r | rec_sel_r);

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || i_link_fail)
		begin
			crs_r <= 1'b0;
			dv_r  <= 1'b0;
			rxd_r <= '0;
			er_r  <= 1'b0;
		end
		else if (rx_fall)
		begin
			crs_r <= crs_nxt;
			dv_r  <= dv_nxt;
			rxd_r <= dv_nxt ? i_rx_nibble : 4'h0;
			er_r  <= dv_nxt & ~speed_r & i_rx_err;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			col_r <= 1'b0;
		else
			col_r <= i_collision;
	end

	////////////////////////////////////////////////////////////////////////////
	assign o_tx_clk     = tx_clk_r;
	assign o_rx_clk     = rx_clk_r;
	assign o_crs        = crs_r;
	assign o_rx_dv      = dv_r;
	assign o_rxd        = rxd_r;
	assign o_rx_er      = er_r;
	assign o_col        = col_r;
	assign o_code       = nib.code;
	assign o_code_stb   = nib.code_stb;
	assign o_scr_bypass = speed_r;
	assign o_man_nibble = man_nibble_r;
	assign o_man_valid  = man_valid_r;

	////////////////////////////////////////////////////////////////////////////
	// helper: oscillator rises between transmit clock rises in slow mode
	logic [7:0] osc_cnt_r;
	logic [1:0] seen_r;

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !speed_r)
		begin
			osc_cnt_r <= '0;
			seen_r    <= '0;
		end
		else if (tx_rise)
		begin
			osc_cnt_r <= '0;
			if (seen_r != 2'h3)
				seen_r <= seen_r + 2'h1;
		end
		else if (osc_rise)
			osc_cnt_r <= osc_cnt_r + 8'h01;
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	fast_follow_a: assert property (!speed_r && $rose(osc_s2_r) |=> $rose(o_tx_clk))
		else $error("fast transmit clock missed an oscillator rise");
	slow_period_a: assert property (speed_r && tx_rise && seen_r == 2'h3
		|-> osc_cnt_r == 8'(2 * SLOW_DIV - 1))
		else $error("slow transmit clock period wrong");
	tx_ignore_a: assert property (tx_rise && !i_tx_en |-> ##2 !o_man_valid)
		else $error("nibble taken while enable low");
	tx_take_a: assert property (tx_rise && i_tx_en && speed_r
		|-> ##2 o_man_valid && o_man_nibble == $past(i_txd, 2))
		else $error("nibble not taken on transmit rise");
	rx_zero_a: assert property (!o_rx_dv |-> o_rxd == 4'h0)
		else $error("receive nibble not zero outside packet");
	rx_edge_a: assert property ($rose(o_rx_dv) || $rose(o_crs) |-> $past(rx_fall))
		else $error("receive status moved off a falling edge");
	rx_end_a: assert property (rx_fall && !i_rx_active |=> !o_crs && !o_rx_dv && o_rxd == 4'h0)
		else $error("packet end not reflected");
	fail_quiet_a: assert property (i_link_fail |=> !o_crs && !o_rx_dv)
		else $error("carrier shown during link fail");
	er_once_a: assert property (o_rx_er && rx_fall && !(dv_nxt && i_rx_err) |=> !o_rx_er)
		else $error("receive error outlived its nibble");
	col_track_a: assert property (##1 o_col == $past(i_collision))
		else $error("collision output does not track");
	er_slow_a: assert property (rx_fall && speed_r |=> !o_rx_er)
		else $error("receive error in slow mode");
	squelch_idle_a: assert property (rx_fall && speed_r && !i_squelch_ok
		|=> !o_crs && !o_rx_dv && o_rxd == 4'h0 && !rec_sel_r)
		else $error("receiver not idle on squelch");
	crs_first_a: assert property (speed_r && $rose(o_rx_dv) |-> $past(o_crs) && rec_sel_r)
		else $error("slow valid before carrier and recovered clock");

	tx_frame_c: cover property (tx_rise && i_tx_en ##[1:200] tx_rise && !i_tx_en);
	rx_packet_c: cover property ($rose(o_rx_dv) ##[1:400] $fell(o_rx_dv));
	slow_rx_c: cover property (speed_r && $rose(o_rx_dv));
	col_c: cover property ($rose(o_col));
endmodule

//--- rtl/pme_pkg.sv
package pme_pkg;

	typedef logic [3:0] pme_nibble_t;
	typedef logic [4:0] pme_code_t;

	// gray along idle -> k -> data -> r -> idle
	typedef enum logic [1:0]
	{
		pme_enc_idle = 2'h0,
		pme_enc_k    = 2'h1,
		pme_enc_data = 2'h3,
		pme_enc_r    = 2'h2
	} pme_enc_state_t;

endpackage

//--- rtl/pme_regs.svh
`ifndef PME_REGS_SVH
`define PME_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// interface clock rates
`define PME_FAST_MHZ 25
`define PME_SLOW_KHZ 2500
// oscillator rising edges per half period of the slow interface clock
`define PME_SLOW_DIV ((`PME_FAST_MHZ * 1000) / (`PME_SLOW_KHZ * 2))

////////////////////////////////////////////////////////////////////////////////
// control code words
`define PME_CODE_I 5'h1f
`define PME_CODE_J 5'h18
`define PME_CODE_K 5'h11
`define PME_CODE_T 5'h0d
`define PME_CODE_R 5'h07

////////////////////////////////////////////////////////////////////////////////
// data code words, nibble 0 to f
`define PME_CODE_D0 5'h1e
`define PME_CODE_D1 5'h09
`define PME_CODE_D2 5'h14
`define PME_CODE_D3 5'h15
`define PME_CODE_D4 5'h0a
`define PME_CODE_D5 5'h0b
`define PME_CODE_D6 5'h0e
`define PME_CODE_D7 5'h0f
`define PME_CODE_D8 5'h12
`define PME_CODE_D9 5'h13
`define PME_CODE_DA 5'h16
`define PME_CODE_DB 5'h17
`define PME_CODE_DC 5'h1a
`define PME_CODE_DD 5'h1b
`define PME_CODE_DE 5'h1c
`define PME_CODE_DF 5'h1d

`endif

//--- verification/pme_mac_model.sv
`timescale 1ns/100ps
module pme_mac_model
(
	// clock and reset
	input  wire logic            i_clk,
	input  wire logic            i_resetn,
	// transmit clock from the device
	input  wire logic            i_tx_clk,
	// transmit side to the device
	output pme_pkg::pme_nibble_t o_txd,
	output logic                 o_tx_en
);
	import pme_pkg::*;

	pme_nibble_t txq[$];
	logic        tx_clk_r = 1'b0;

	task automatic load(input pme_nibble_t n);
		txq.push_back(n);
	endtask

	// changes one system clock after a tx clock rise, so the lines are settled at the next rise
	always @(posedge i_clk)
	begin
		tx_clk_r <= i_tx_clk;
		if (!i_resetn)
		begin
			o_tx_en <= 1'b0;
			o_txd   <= 4'h0;
		end
		else if (i_tx_clk && !tx_clk_r)
		begin
			if (txq.size() > 0)
			begin
				o_tx_en <= 1'b1;
				o_txd   <= txq.pop_front();
			end
			else
			begin
				// enable dropped at a rise; data lines no longer hold the last nibble
				o_tx_en <= 1'b0;
				o_txd   <= ~o_txd;
			end
		end
	end
endmodule

//--- verification/pme_phy_mii_tb.sv
`timescale 1ns/100ps
module pme_phy_mii_tb;
	import pme_pkg::*;

	localparam int SLOW_DIV = 2;
	// system clocks per oscillator period: 80 ns at a 4 ns clock
	localparam int OSC_CLKS = 20;

	logic        i_clk = 1'b0;
	logic        i_resetn = 1'b0;
	logic        i_oscillator_input = 1'b0;
	logic        i_speed_10 = 1'b0;
	logic        i_rx_active = 1'b0;
	pme_nibble_t i_rx_nibble = 4'h0;
	logic        i_rx_err = 1'b0;
	logic        i_squelch_ok = 1'b0;
	logic        i_rec_lock = 1'b0;
	logic        i_rec_clk = 1'b0;
	logic        i_link_fail = 1'b0;
	logic        i_collision = 1'b0;
	logic        tx_en;
	pme_nibble_t txd;
	logic        o_tx_clk, o_rx_clk, o_crs, o_rx_dv, o_rx_er, o_col;
	logic        o_code_stb, o_scr_bypass, o_man_valid;
	pme_nibble_t o_rxd, o_man_nibble;
	pme_code_t   o_code;
	pme_code_t   codes[$];
	int          n_mismatch = 0;
	int          samples_checked = 0;
	int          osc_cnt = 0;
	int          rec_cnt = 0;
	// data codes for nibbles 0 to f
	logic [4:0]  tbl[16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

	always #2 i_clk = ~i_clk;

	// oscillator and recovered clock both 80 ns, changed on the sampling edge
	always @(posedge i_clk)
	begin
		osc_cnt <= (osc_cnt == OSC_CLKS / 2 - 1) ? 0 : osc_cnt + 1;
		rec_cnt <= (rec_cnt == 9) ? 0 : rec_cnt + 1;
		if (osc_cnt == OSC_CLKS / 2 - 1)
			i_oscillator_input <= ~i_oscillator_input;
		if (rec_cnt == 9)
			i_rec_clk <= ~i_rec_clk;
		if (o_code_stb === 1'b1)
			codes.push_back(o_code);
	end

	pme_mac_model mac
	(
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_tx_clk (o_tx_clk),
		.o_txd    (txd),
		.o_tx_en  (tx_en)
	);

	pme_phy_mii #(.SLOW_DIV(SLOW_DIV)) uut
	(
		.i_clk(i_clk), .i_resetn(i_resetn), .i_oscillator_input(i_oscillator_input),
		.i_speed_10(i_speed_10), .i_tx_en(tx_en), .i_txd(txd), .o_tx_clk(o_tx_clk),
		.o_rx_clk(o_rx_clk), .o_crs(o_crs), .o_rx_dv(o_rx_dv), .o_rxd(o_rxd),
		.o_rx_er(o_rx_er), .o_col(o_col), .i_rx_active(i_rx_active),
		.i_rx_nibble(i_rx_nibble), .i_rx_err(i_rx_err), .i_squelch_ok(i_squelch_ok),
		.i_rec_lock(i_rec_lock), .i_rec_clk(i_rec_clk), .i_link_fail(i_link_fail),
		.i_collision(i_collision), .o_code(o_code), .o_code_stb(o_code_stb),
		.o_scr_bypass(o_scr_bypass), .o_man_nibble(o_man_nibble), .o_man_valid(o_man_valid)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic stop_test;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// sel 0 tx clock, 1 rx clock, 2 manchester valid; n counts the clocks waited
	task automatic wait_on(input int sel, input logic lvl, inout int n);
		int   k;
		logic v;
		k = 0;
		do
		begin
			@(posedge i_clk);
			#1;
			k++;
			n++;
			v = (sel == 0) ? o_tx_clk : (sel == 1) ? o_rx_clk : o_man_valid;
		end
		while (v !== lvl && k < 2000);
		if (k >= 2000)
		begin
			n_mismatch++;
			$display("[ERR] %0t wait timed out", $time);
		end
	endtask

	task automatic tx_period(input int exp);
		int d, n;
		d = 0;
		n = 0;
		wait_on(0, 1'b0, d);
		wait_on(0, 1'b1, d);
		wait_on(0, 1'b0, n);
		wait_on(0, 1'b1, n);
		check(n, exp, "tx clock period");
	endtask

	// present one decoded nibble and return just after the rx clock fall that takes it
	// waits for a fresh rise so the inputs settle well before the fall
	task automatic rx_step(input logic act, input pme_nibble_t nib, input logic err);
		int d;
		d = 0;
		wait_on(1, 1'b0, d);
		wait_on(1, 1'b1, d);
		@(posedge i_clk);
		i_rx_active <= act;
		i_rx_nibble <= nib;
		i_rx_err    <= err;
		wait_on(1, 1'b0, d);
	endtask

	// line side status, changed on a clock rise
	task automatic set_line(input logic spd, input logic sq, input logic lock,
		input logic fail, input logic col);
		@(posedge i_clk);
		i_speed_10   <= spd;
		i_squelch_ok <= sq;
		i_rec_lock   <= lock;
		i_link_fail  <= fail;
		i_collision  <= col;
	endtask

	task automatic t_idle;
		check(o_code, 5'h1f, "idle code");
		check({o_crs, o_rx_dv, o_rx_er, o_rxd}, 8'h00, "rx idle");
		tx_period(OSC_CLKS);
	endtask

	task automatic t_tx;
		logic [4:0] exp[$];
		int         k, s;
		codes.delete();
		exp = '{5'h18, 5'h11};
		mac.load(4'h5);
		mac.load(4'h5);
		for (int i = 0; i < 16; i++)
		begin
			mac.load(i[3:0]);
			exp.push_back(tbl[i]);
		end
		exp.push_back(5'h0d);
		exp.push_back(5'h07);
		exp.push_back(5'h1f);
		exp.push_back(5'h1f);
		k = 0;
		while (codes.size() < 30 && k < 2000)
		begin
			@(posedge i_clk);
			k++;
		end
		s = 0;
		while (s < codes.size() && codes[s] === 5'h1f)
			s++;
		for (int i = 0; i < exp.size(); i++)
			check((s + i < codes.size()) ? codes[s + i] : 5'h00, exp[i], "code");
	endtask

	task automatic t_rx;
		rx_step(1'b1, 4'h5, 1'b0);
		check({o_crs, o_rx_dv, o_rx_er, o_rxd}, 8'h65, "rx start");
		rx_step(1'b1, 4'ha, 1'b1);
		check({o_crs, o_rx_dv, o_rx_er, o_rxd}, 8'h7a, "rx error");
		rx_step(1'b1, 4'h3, 1'b0);
		check({o_crs, o_rx_dv, o_rx_er, o_rxd}, 8'h63, "rx after error");
		rx_step(1'b0, 4'h0, 1'b0);
		check({o_crs, o_rx_dv, o_rx_er, o_rxd}, 8'h00, "rx end");
	endtask

	task automatic t_fail;
		set_line(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		rx_step(1'b1, 4'h5, 1'b0);
		check({o_crs, o_rx_dv}, 8'h00, "link fail");
		rx_step(1'b0, 4'h0, 1'b0);
		set_line(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
	endtask

	task automatic t_col;
		set_line(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
		@(posedge i_clk);
		#1;
		check(o_col, 1'b1, "collision on");
		repeat (6) @(posedge i_clk);
		#1;
		check(o_col, 1'b1, "collision held");
		set_line(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge i_clk);
		@(posedge i_clk);
		#1;
		check(o_col, 1'b0, "collision off");
	endtask

	task automatic t_slow;
		int d;
		d = 0;
		set_line(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		repeat (200) @(posedge i_clk);
		#1;
		codes.delete();
		check(o_scr_bypass, 1'b1, "bypass");
		tx_period(2 * SLOW_DIV * OSC_CLKS);
		mac.load(4'h3);
		mac.load(4'hc);
		wait_on(2, 1'b1, d);
		check(o_man_nibble, 4'h3, "manchester nibble");
		rx_step(1'b1, 4'h6, 1'b0);
		check({o_crs, o_rx_dv, o_rxd}, 8'h00, "squelch idle");
		set_line(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		rx_step(1'b1, 4'h5, 1'b1);
		check({o_crs, o_rx_dv, o_rx_er}, 8'h04, "carrier first");
		set_line(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 8 && o_rx_dv !== 1'b1; i++)
			rx_step(1'b1, 4'h9, 1'b1);
		check({o_crs, o_rx_dv, o_rx_er, o_rxd}, 8'h69, "valid after lock");
		rx_step(1'b0, 4'h0, 1'b0);
		check({o_crs, o_rx_dv}, 8'h00, "slow end");
		check(codes.size(), 8'h00, "no codes in slow mode");
	endtask

	initial
	begin
		#200000;
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end

	initial
	begin
		repeat (5) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		#1;
		t_idle();
		t_tx();
		t_rx();
		t_fail();
		t_col();
		t_slow();
		stop_test();
	end
endmodule
